// ---- msi_top.sv ----
// What this block does
// - Interrupt pin active low when polarity bit is 1, else active high.
// - Interrupt pin open drain when drive-type bit is 1, else push-pull.
// - Latch bit holds pin until status cleared; otherwise 50us pulse per interrupt.
// - Any-read-clear bit makes every read clear status; else only status reads.
// - Sync-level bit selects active-low or active-high frame sync input.
// - Sync enable lets frame sync reaching active level raise an interrupt.
// - Overflow reaches interrupt output only while its enable bit is set.
// - Enable bit gates gyro drive-ready source onto the interrupt output.
// - Enable bit gates data-ready source onto the interrupt output.
// - Motion-wake event shows as 111 in status; status read clears it.
// - Overflow sets its status bit; status read clears it.
// - Status bit records gyro drive-ready interrupt.
// - Data-ready sets its status bit; status read clears it.
// - Accel axes read as 16-bit values, high byte at lower address.
// - Temperature reads as 16-bit value, high byte first.
// - Frame sync interrupt sets its status bit; reading it clears it.
// - Motion-wake status arises only while motion detection is enabled.
module msi_top #(
  parameter int unsigned PULSE_CYCLES = msi_pkg::PULSE_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic frame_sync_pin,
  input wire logic motion_wake_event,
  input wire logic overflow_event,
  input wire logic gyro_drive_ready_event,
  input wire logic data_ready_event,
  input wire logic sample_valid,
  input wire logic [15:0] accel_x,
  input wire logic [15:0] accel_y,
  input wire logic [15:0] accel_z,
  input wire logic [15:0] temperature,
  input wire logic irq_output_pin_i,
  output logic irq_output_pin_o,
  output logic irq_output_pin_oe
);

  // Picks one byte of a 16-bit result, high byte for the lower address
  function automatic logic [7:0] msi_byte(input logic [15:0] word, input logic high);
    msi_byte = high ? word[15:8] : word[7:0];
  endfunction

  // Address match for a write or read strobe
  function automatic logic msi_hit(input logic strobe, input logic [7:0] addr,
                                   input logic [7:0] target);
    msi_hit = strobe && (addr == target);
  endfunction

  logic [7:0] pin_cfg_q, pin_cfg_d;
  logic [7:0] src_en_q, src_en_d;
  logic [7:0] motion_ctrl_q, motion_ctrl_d;
  logic [7:0] status_q, status_d;
  logic sync_status_q, sync_status_d;
  logic sync_meta_q, sync_stable_q, sync_prev_q;
  logic [15:0] accel_x_q, accel_x_d;
  logic [15:0] accel_y_q, accel_y_d;
  logic [15:0] accel_z_q, accel_z_d;
  logic [15:0] temp_q, temp_d;
  logic [7:0] rdata_q, rdata_d;
  logic sync_now;
  logic sync_before;
  logic sync_edge;
  logic clr_main;
  logic clr_sync;
  logic [7:0] set_vec;
  logic set_sync;
  logic [7:0] gate_vec;
  logic pending;
  logic trigger;

  msi_pin_if pin_bus ();

  // Configuration registers; reserved bits never store
  always_comb begin
    pin_cfg_d = pin_cfg_q;
    src_en_d = src_en_q;
    motion_ctrl_d = motion_ctrl_q;
    if (msi_hit(reg_wr, reg_addr, msi_pkg::ADDR_PIN_CFG)) begin
      pin_cfg_d = reg_wdata & msi_pkg::PIN_CFG_WMASK;
    end
    if (msi_hit(reg_wr, reg_addr, msi_pkg::ADDR_SRC_ENABLE)) begin
      src_en_d = reg_wdata & msi_pkg::SRC_ENABLE_WMASK;
    end
    if (msi_hit(reg_wr, reg_addr, msi_pkg::ADDR_MOTION_CTRL)) begin
      motion_ctrl_d = reg_wdata & msi_pkg::MOTION_CTRL_WMASK;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_cfg_q <= msi_pkg::CFG_RESET;
      src_en_q <= msi_pkg::CFG_RESET;
      motion_ctrl_q <= msi_pkg::CFG_RESET;
    end else if (ce) begin
      pin_cfg_q <= pin_cfg_d;
      src_en_q <= src_en_d;
      motion_ctrl_q <= motion_ctrl_d;
    end
  end

  // Frame sync arrives from a pin: two flops, then a third for edge history
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_meta_q <= 1'b0;
      sync_stable_q <= 1'b0;
      sync_prev_q <= 1'b0;
    end else if (ce) begin
      sync_meta_q <= frame_sync_pin;
      sync_stable_q <= sync_meta_q;
      sync_prev_q <= sync_stable_q;
    end
  end

  // Normalise to active-high, then look for entry into the active level
  assign sync_now = sync_stable_q ^ pin_cfg_q[msi_pkg::SYNC_POLARITY_BIT];
  assign sync_before = sync_prev_q ^ pin_cfg_q[msi_pkg::SYNC_POLARITY_BIT];
  assign sync_edge = sync_now && !sync_before;

  // Sources that set status this cycle
  always_comb begin
    set_vec = 8'h00;
    if (motion_wake_event && motion_ctrl_q[msi_pkg::MOTION_DETECT_BIT]) begin
      set_vec[msi_pkg::MOTION_WAKE_MSB:msi_pkg::MOTION_WAKE_LSB] = msi_pkg::MOTION_WAKE_ON;
    end
    set_vec[msi_pkg::OVERFLOW_BIT] = overflow_event;
    set_vec[msi_pkg::GYRO_DRIVE_BIT] = gyro_drive_ready_event;
    set_vec[msi_pkg::DATA_READY_BIT] = data_ready_event;
    set_sync = sync_edge && pin_cfg_q[msi_pkg::SYNC_IRQ_EN_BIT];
  end

  // Read-to-clear: a set in the same cycle as the clearing read survives
  always_comb begin
    clr_main = reg_rd && (pin_cfg_q[msi_pkg::PIN_ANY_RD_CLR_BIT]
                          || reg_addr == msi_pkg::ADDR_SRC_STATUS);
    clr_sync = reg_rd && (pin_cfg_q[msi_pkg::PIN_ANY_RD_CLR_BIT]
                          || reg_addr == msi_pkg::ADDR_SYNC_STATUS);
    status_d = (clr_main ? 8'h00 : status_q) | set_vec;
    sync_status_d = (clr_sync ? 1'b0 : sync_status_q) | set_sync;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_q <= 8'h00;
      sync_status_q <= 1'b0;
    end else if (ce) begin
      status_q <= status_d;
      sync_status_q <= sync_status_d;
    end
  end

  // Results captured whole per sample so both bytes of a pair agree
  always_comb begin
    accel_x_d = accel_x_q;
    accel_y_d = accel_y_q;
    accel_z_d = accel_z_q;
    temp_d = temp_q;
    if (sample_valid) begin
      accel_x_d = accel_x;
      accel_y_d = accel_y;
      accel_z_d = accel_z;
      temp_d = temperature;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      accel_x_q <= msi_pkg::RESULT_RESET;
      accel_y_q <= msi_pkg::RESULT_RESET;
      accel_z_q <= msi_pkg::RESULT_RESET;
      temp_q <= msi_pkg::RESULT_RESET;
    end else if (ce) begin
      accel_x_q <= accel_x_d;
      accel_y_q <= accel_y_d;
      accel_z_q <= accel_z_d;
      temp_q <= temp_d;
    end
  end

  // Read data, registered; unmapped offsets read zero
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        msi_pkg::ADDR_SYNC_STATUS: rdata_d = {sync_status_q, 7'h00};
        msi_pkg::ADDR_PIN_CFG: rdata_d = pin_cfg_q;
        msi_pkg::ADDR_SRC_ENABLE: rdata_d = src_en_q;
        msi_pkg::ADDR_SRC_STATUS: rdata_d = status_q;
        msi_pkg::ADDR_ACCEL_X_HIGH: rdata_d = msi_byte(accel_x_q, 1'b1);
        msi_pkg::ADDR_ACCEL_X_LOW: rdata_d = msi_byte(accel_x_q, 1'b0);
        msi_pkg::ADDR_ACCEL_Y_HIGH: rdata_d = msi_byte(accel_y_q, 1'b1);
        msi_pkg::ADDR_ACCEL_Y_LOW: rdata_d = msi_byte(accel_y_q, 1'b0);
        msi_pkg::ADDR_ACCEL_Z_HIGH: rdata_d = msi_byte(accel_z_q, 1'b1);
        msi_pkg::ADDR_ACCEL_Z_LOW: rdata_d = msi_byte(accel_z_q, 1'b0);
        msi_pkg::ADDR_TEMP_HIGH: rdata_d = msi_byte(temp_q, 1'b1);
        msi_pkg::ADDR_TEMP_LOW: rdata_d = msi_byte(temp_q, 1'b0);
        msi_pkg::ADDR_MOTION_CTRL: rdata_d = motion_ctrl_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else if (ce) begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // Enable gating; motion wake needs all three enable bits
  always_comb begin
    gate_vec = src_en_q;
    gate_vec[msi_pkg::MOTION_WAKE_MSB:msi_pkg::MOTION_WAKE_LSB] =
      {3{src_en_q[msi_pkg::MOTION_WAKE_MSB:msi_pkg::MOTION_WAKE_LSB]
         == msi_pkg::MOTION_WAKE_ON}};
    gate_vec[msi_pkg::OVERFLOW_BIT] = src_en_q[msi_pkg::OVERFLOW_BIT];
    gate_vec[msi_pkg::GYRO_DRIVE_BIT] = src_en_q[msi_pkg::GYRO_DRIVE_BIT];
    gate_vec[msi_pkg::DATA_READY_BIT] = src_en_q[msi_pkg::DATA_READY_BIT];
    pending = (|(status_q & gate_vec)) || sync_status_q;
    trigger = (|(set_vec & gate_vec)) || set_sync;
  end

  // Pin stage receives live config so mode changes act at once
  assign pin_bus.trig = trigger;
  assign pin_bus.hold = pending;
  assign pin_bus.latch_en = pin_cfg_q[msi_pkg::PIN_LATCH_BIT];
  assign pin_bus.act_low = pin_cfg_q[msi_pkg::PIN_ACT_LOW_BIT];
  assign pin_bus.open_drain = pin_cfg_q[msi_pkg::PIN_OPEN_DRAIN_BIT];

  msi_irq_pin #(
    .PULSE_CYCLES(PULSE_CYCLES)
  ) u_irq_pin (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .pin(pin_bus.drv)
  );

  assign irq_output_pin_o = pin_bus.pin_o;
  assign irq_output_pin_oe = pin_bus.pin_oe;

  AST_SYNC_RAISES:
    assert property (@(posedge clk) disable iff (sys_rst)
      ce && sync_edge && pin_cfg_q[msi_pkg::SYNC_IRQ_EN_BIT] |=> sync_status_q)
    else $error("frame sync edge lost");

  AST_SYNC_DISABLED:
    assert property (@(posedge clk) disable iff (sys_rst)
      ce && !pin_cfg_q[msi_pkg::SYNC_IRQ_EN_BIT] && !sync_status_q |=> !sync_status_q)
    else $error("disabled frame sync raised status");

  AST_SYNC_READ_CLEARS:
    assert property (@(posedge clk) disable iff (sys_rst)
      ce && msi_hit(reg_rd, reg_addr, msi_pkg::ADDR_SYNC_STATUS) && !set_sync
        |=> !sync_status_q)
    else $error("frame sync status survived its read");

  AST_MOTION_SETS_ALL:
    assert property (@(posedge clk) disable iff (sys_rst)
      ce && motion_wake_event && motion_ctrl_q[msi_pkg::MOTION_DETECT_BIT]
        |=> status_q[7:5] == 3'h7)
    else $error("motion wake not reported as all ones");

  AST_MOTION_NEEDS_DETECT:
    assert property (@(posedge clk) disable iff (sys_rst)
      ce && !motion_ctrl_q[msi_pkg::MOTION_DETECT_BIT] && status_q[7:5] == 3'h0
        |=> status_q[7:5] == 3'h0)
    else $error("motion wake status without detection enabled");

  AST_SET_BEATS_CLEAR:
    assert property (@(posedge clk) disable iff (sys_rst)
      ce && overflow_event && clr_main |=> status_q[4])
    else $error("overflow lost against clearing read");

  AST_DRDY_SETS:
    assert property (@(posedge clk) disable iff (sys_rst)
      ce && data_ready_event |=> status_q[0])
    else $error("data ready status not set");

  AST_STATUS_READ_CLEARS:
    assert property (@(posedge clk) disable iff (sys_rst)
      ce && clr_main && set_vec == 8'h00 |=> status_q == 8'h00 && !$past(reg_wr))
    else $error("status not cleared by read");

  AST_OTHER_READ_KEEPS:
    assert property (@(posedge clk) disable iff (sys_rst)
      ce && reg_rd && !pin_cfg_q[msi_pkg::PIN_ANY_RD_CLR_BIT]
        && reg_addr != msi_pkg::ADDR_SRC_STATUS |=> status_q == $past(status_q | set_vec))
    else $error("status cleared by unrelated read");

  AST_STATUS_READBACK:
    assert property (@(posedge clk) disable iff (sys_rst)
      ce && msi_hit(reg_rd, reg_addr, msi_pkg::ADDR_SRC_STATUS) |=> reg_rdata == $past(status_q))
    else $error("status read returned wrong value");

  AST_ACCEL_HIGH_FIRST:
    assert property (@(posedge clk) disable iff (sys_rst)
      ce && msi_hit(reg_rd, reg_addr, msi_pkg::ADDR_ACCEL_X_HIGH)
        |=> reg_rdata == $past(accel_x_q[15:8]))
    else $error("accel x high byte misplaced");

  AST_TEMP_HIGH_FIRST:
    assert property (@(posedge clk) disable iff (sys_rst)
      ce && msi_hit(reg_rd, reg_addr, msi_pkg::ADDR_TEMP_HIGH)
        |=> reg_rdata == $past(temp_q[15:8]))
    else $error("temperature high byte misplaced");

  AST_OVERFLOW_GATED:
    assert property (@(posedge clk) disable iff (sys_rst)
      ce && !src_en_q[msi_pkg::OVERFLOW_BIT] && set_vec == 8'h10 && !set_sync
        |-> !trigger)
    else $error("overflow triggered while disabled");

endmodule

// ---- msi_pkg.sv ----
package msi_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_SYNC_STATUS = 8'h36;
  localparam logic [7:0] ADDR_PIN_CFG = 8'h37;
  localparam logic [7:0] ADDR_SRC_ENABLE = 8'h38;
  localparam logic [7:0] ADDR_SRC_STATUS = 8'h3a;
  localparam logic [7:0] ADDR_ACCEL_X_HIGH = 8'h3b;
  localparam logic [7:0] ADDR_ACCEL_X_LOW = 8'h3c;
  localparam logic [7:0] ADDR_ACCEL_Y_HIGH = 8'h3d;
  localparam logic [7:0] ADDR_ACCEL_Y_LOW = 8'h3e;
  localparam logic [7:0] ADDR_ACCEL_Z_HIGH = 8'h3f;
  localparam logic [7:0] ADDR_ACCEL_Z_LOW = 8'h40;
  localparam logic [7:0] ADDR_TEMP_HIGH = 8'h41;
  localparam logic [7:0] ADDR_TEMP_LOW = 8'h42;
  localparam logic [7:0] ADDR_MOTION_CTRL = 8'h69;

  // Pin configuration fields
  localparam int PIN_ACT_LOW_BIT = 7;
  localparam int PIN_OPEN_DRAIN_BIT = 6;
  localparam int PIN_LATCH_BIT = 5;
  localparam int PIN_ANY_RD_CLR_BIT = 4;
  localparam int SYNC_POLARITY_BIT = 3;
  localparam int SYNC_IRQ_EN_BIT = 2;

  // Source enable and status fields
  localparam int MOTION_WAKE_MSB = 7;
  localparam int MOTION_WAKE_LSB = 5;
  localparam int OVERFLOW_BIT = 4;
  localparam int GYRO_DRIVE_BIT = 2;
  localparam int DATA_READY_BIT = 0;
  localparam int SYNC_STATUS_BIT = 7;
  localparam int MOTION_DETECT_BIT = 7;
  localparam logic [2:0] MOTION_WAKE_ON = 3'h7;

  // Writable bits; reserved and always-zero bits read back as zero
  localparam logic [7:0] PIN_CFG_WMASK = 8'hfc;
  localparam logic [7:0] SRC_ENABLE_WMASK = 8'hf5;
  localparam logic [7:0] MOTION_CTRL_WMASK = 8'hc0;

  // Values after reset
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // Interrupt pulse width
  localparam int PULSE_NS = 50000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int PULSE_CYCLES = PULSE_NS / CLK_PERIOD_NS;
  localparam int PULSE_CNT_W = 16;

  typedef enum logic [1:0] {
    MSI_PIN_IDLE = 2'b01,
    MSI_PIN_PULSE = 2'b10
  } msi_pin_state_t;

endpackage

// ---- msi_pin_if.sv ----
interface msi_pin_if;
  logic trig;
  logic hold;
  logic latch_en;
  logic act_low;
  logic open_drain;
  logic pin_o;
  logic pin_oe;

  modport ctrl (
    output trig,
    output hold,
    output latch_en,
    output act_low,
    output open_drain,
    input pin_o,
    input pin_oe
  );

  modport drv (
    input trig,
    input hold,
    input latch_en,
    input act_low,
    input open_drain,
    output pin_o,
    output pin_oe
  );
endinterface

// ---- msi_irq_pin.sv ----
module msi_irq_pin #(
  parameter int unsigned PULSE_CYCLES = msi_pkg::PULSE_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  msi_pin_if.drv pin
);

  localparam logic [msi_pkg::PULSE_CNT_W-1:0] PULSE_LOAD =
    msi_pkg::PULSE_CNT_W'(PULSE_CYCLES - 1);

  msi_pkg::msi_pin_state_t state_q, state_d;
  logic [msi_pkg::PULSE_CNT_W-1:0] cnt_q, cnt_d;
  logic pin_o_q, pin_o_d;
  logic pin_oe_q, pin_oe_d;
  logic asserted;
  logic level;
  logic seen_level;

  // Pulse timer; a new event restarts the full width
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      msi_pkg::MSI_PIN_IDLE: begin
        if (pin.trig && !pin.latch_en) begin
          state_d = msi_pkg::MSI_PIN_PULSE;
          cnt_d = PULSE_LOAD;
        end
      end
      msi_pkg::MSI_PIN_PULSE: begin
        if (pin.latch_en) begin
          state_d = msi_pkg::MSI_PIN_IDLE;
        end else if (pin.trig) begin
          cnt_d = PULSE_LOAD;
        end else if (cnt_q == '0) begin
          state_d = msi_pkg::MSI_PIN_IDLE;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: begin
        state_d = msi_pkg::MSI_PIN_IDLE;
      end
    endcase
    // Latched mode follows pending status, pulse mode the timer
    asserted = pin.latch_en ? pin.hold : (state_d == msi_pkg::MSI_PIN_PULSE);
    level = asserted ^ pin.act_low;
    // Open drain only ever pulls low; a high level is left to the pull-up
    if (pin.open_drain) begin
      pin_o_d = 1'b0;
      pin_oe_d = !level;
    end else begin
      pin_o_d = level;
      pin_oe_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= msi_pkg::MSI_PIN_IDLE;
      cnt_q <= '0;
      pin_o_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pin_o_q <= pin_o_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  assign pin.pin_o = pin_o_q;
  assign pin.pin_oe = pin_oe_q;

  // Wire level as seen outside, released open drain reads high
  assign seen_level = pin_oe_q ? pin_o_q : 1'b1;

  AST_PIN_LATCH_LEVEL:
    assert property (@(posedge clk) disable iff (sys_rst)
      ce && pin.latch_en && pin.hold |=> seen_level == !$past(pin.act_low))
    else $error("latched interrupt not shown at configured level");

  AST_PIN_IDLE_LEVEL:
    assert property (@(posedge clk) disable iff (sys_rst)
      ce && pin.latch_en && !pin.hold |=> seen_level == $past(pin.act_low))
    else $error("interrupt pin active without pending status");

  AST_PUSH_PULL_DRIVES:
    assert property (@(posedge clk) disable iff (sys_rst)
      ce && !sys_rst && !pin.open_drain |=> pin_oe_q) // Release edge still resets flops
    else $error("push-pull pin not driven");

  AST_OPEN_DRAIN_LOW_ONLY:
    assert property (@(posedge clk) disable iff (sys_rst)
      ce && pin.open_drain |=> !(pin_oe_q && pin_o_q))
    else $error("open-drain pin driven high");

  AST_PULSE_START:
    assert property (@(posedge clk) disable iff (sys_rst)
      ce && !pin.latch_en && pin.trig |=> state_q == msi_pkg::MSI_PIN_PULSE
        && cnt_q == PULSE_LOAD)
    else $error("pulse not started with full width");

  AST_PULSE_ENDS:
    assert property (@(posedge clk) disable iff (sys_rst)
      ce && !pin.latch_en && !pin.trig && state_q == msi_pkg::MSI_PIN_PULSE
        && cnt_q == '0 |=> state_q == msi_pkg::MSI_PIN_IDLE)
    else $error("pulse outlived its width");

endmodule

// ---- msi_host.sv ----
// Register-port host; strobes change just after an edge and drop after the taking edge
module msi_host (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  output logic rd_vld
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle values at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    rd_vld = 1'b0;
  end

  // Address and data are scrambled once released so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // Flag marks the cycle in which read data is valid for the watcher
  task automatic rd(input logic [7:0] a, input logic note);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    rd_vld <= note;
    @(posedge clk);
    rd_vld <= 1'b0;
  endtask

  // Motion enable field only ever gets all ones or all zeros
  task automatic set_enable(input logic motion_on, input logic [4:0] others);
    wr(msi_pkg::ADDR_SRC_ENABLE, {motion_on ? 3'h7 : 3'h0, others});
  endtask
endmodule

// ---- testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PW = 20;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic frame_sync_pin = 1'b0;
  logic [3:0] ev = 4'h0;
  logic sample_valid = 1'b0;
  logic [15:0] res [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic rd_vld;
  logic [7:0] reg_rdata;
  logic pin_o;
  logic pin_oe;
  logic pin_w;
  logic [7:0] exp_q [$];
  logic [7:0] r;
  int fails = 0;
  int compares = 0;
  int n;

  // Pull-up on the wire when nobody drives it
  assign pin_w = pin_oe ? pin_o : 1'b1;

  // 200 MHz
  always #2.5 clk = ~clk;

  msi_host host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .rd_vld(rd_vld));

  msi_top #(.PULSE_CYCLES(PW)) dut (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .frame_sync_pin(frame_sync_pin), .motion_wake_event(ev[3]),
    .overflow_event(ev[2]), .gyro_drive_ready_event(ev[1]), .data_ready_event(ev[0]),
    .sample_valid(sample_valid), .accel_x(res[0]), .accel_y(res[1]), .accel_z(res[2]),
    .temperature(res[3]), .irq_output_pin_i(pin_w), .irq_output_pin_o(pin_o),
    .irq_output_pin_oe(pin_oe));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    // Reads still owed at the end count as misses
    if (exp_q.size() != 0) fails++;
    if (fails == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a, 1'b1);
  endtask

  task automatic ev_pulse(input logic [3:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 4'h0;
  endtask

  // Wire level and enable judged mid-cycle, after the edge has settled
  task automatic pin_chk(input logic asserted, input logic pol, input logic od);
    @(negedge clk);
    check("pin", {7'h00, pin_w}, {7'h00, asserted ^ pol});
    if (od) check("oe", {7'h00, pin_oe}, {7'h00, !(asserted ^ pol)});
  endtask

  // Read data is valid from the edge after the strobe until the next read
  always @(negedge clk) begin
    if (rd_vld && exp_q.size() > 0) check("rdata", reg_rdata, exp_q.pop_front());
  end

  // Watchdog: the full sequence needs well under 5000 cycles
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    conclude();
  end

  initial begin
    void'($urandom(79));
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (exp_q[i]) exp_q.delete();
    rd_exp(8'h37, 8'h00);
    rd_exp(8'h38, 8'h00);
    rd_exp(8'h3a, 8'h00);
    rd_exp(8'h00, 8'h00);
    // Write masks with random data
    r = 8'($urandom);
    host.wr(8'h37, r);
    rd_exp(8'h37, r & 8'hfc);
    r = 8'($urandom);
    host.wr(8'h38, r);
    rd_exp(8'h38, r & 8'hf5);
    // A write while the clock enable is low is lost
    ce <= 1'b0;
    host.wr(8'h38, 8'hff);
    ce <= 1'b1;
    rd_exp(8'h38, r & 8'hf5);
    host.wr(8'h37, 8'h00);
    host.wr(8'h38, 8'h00);
    // Results captured on sample_valid, high byte first
    @(posedge clk);
    for (int i = 0; i < 4; i++) res[i] <= 16'($urandom);
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd_exp(8'h3b + 8'(2 * i), res[i][15:8]);
      rd_exp(8'h3c + 8'(2 * i), res[i][7:0]);
    end
    // Status bits, motion only with detection enabled
    host.wr(8'h69, 8'h00);
    ev_pulse(4'hf);
    rd_exp(8'h3a, 8'h15);
    host.wr(8'h69, 8'h80);
    ev_pulse(4'hf);
    rd_exp(8'h3a, 8'hf5);
    rd_exp(8'h3a, 8'h00);
    // Overflow in the same cycle as the clearing read survives it
    fork
      ev_pulse(4'h4);
      rd_exp(8'h3a, 8'h00);
    join
    rd_exp(8'h3a, 8'h10);
    // Clearing by any read versus status read only
    host.wr(8'h37, 8'h10);
    ev_pulse(4'h1);
    host.rd(8'h00, 1'b0);
    rd_exp(8'h3a, 8'h00);
    host.wr(8'h37, 8'h00);
    ev_pulse(4'h1);
    rd_exp(8'h3b, res[0][15:8]);
    rd_exp(8'h3a, 8'h01);
    // Latched pin in all polarity and drive modes
    for (int m = 0; m < 4; m++) begin
      host.wr(8'h37, {m[0], m[1], 1'b1, 5'h00});
      host.set_enable(1'b0, 5'h01);
      ev_pulse(4'h4);
      repeat (2) @(negedge clk);
      pin_chk(1'b0, m[0], m[1]);
      ev_pulse(4'h1);
      repeat (2) @(negedge clk);
      pin_chk(1'b1, m[0], m[1]);
      rd_exp(8'h3a, 8'h11);
      repeat (2) @(negedge clk);
      pin_chk(1'b0, m[0], m[1]);
    end
    // Pulse mode on a motion event
    host.wr(8'h37, 8'h00);
    host.set_enable(1'b1, 5'h00);
    ev_pulse(4'h8);
    n = 0;
    repeat (3 * PW) begin
      @(negedge clk);
      if (pin_w === 1'b1) n++;
    end
    check("pulse", 8'(n), 8'(PW));
    rd_exp(8'h3a, 8'he0);
    // Frame sync edges for both polarities, enabled then disabled
    for (int p = 0; p < 2; p++) begin
      frame_sync_pin <= p[0];
      host.wr(8'h37, {4'h0, p[0], 1'b1, 2'b00});
      repeat (4) @(posedge clk);
      host.rd(8'h36, 1'b0);
      frame_sync_pin <= ~p[0];
      repeat (5) @(posedge clk);
      rd_exp(8'h36, 8'h80);
      rd_exp(8'h36, 8'h00);
      host.wr(8'h37, {4'h0, p[0], 1'b0, 2'b00});
      frame_sync_pin <= p[0];
      repeat (5) @(posedge clk);
      frame_sync_pin <= ~p[0];
      repeat (5) @(posedge clk);
      rd_exp(8'h36, 8'h00);
    end
    conclude();
  end
endmodule
